// file: src/rms_defines.vh
`ifndef RMS_DEFINES_VH
`define RMS_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------------
`define RMS_ADR_UART3_INPUT_SELECT      8'h00
`define RMS_ADR_UART4_INPUT_SELECT      8'h04
`define RMS_ADR_SERIAL_IN1_INPUT_SELECT 8'h08
`define RMS_ADR_SERIAL_IN2_INPUT_SELECT 8'h0C
`define RMS_ADR_FAULT_INPUT_SELECT      8'h10
`define RMS_ADR_CHANGE_NOTIFY_A_SELECT  8'h14
`define RMS_ADR_CHANGE_NOTIFY_B_SELECT  8'h18
`define RMS_ADR_EXT_EXTERNAL_INTERRUPT_1_INPUT_SELECT   8'h1C
`define RMS_ADR_CARRIER_INPUT_SELECT    8'h20
`define RMS_ADR_CAPTURE5_INPUT_SELECT   8'h24
`define RMS_ADR_CAPTURE7_INPUT_SELECT   8'h28
`define RMS_ADR_CAPTURE8_9_INPUT_SELECT 8'h2C
`define RMS_ADR_TIMER0_CLOCK_SELECT     8'h30
`define RMS_ADR_TIMER1_INPUT_SELECT     8'h34
`define RMS_ADR_TIMER3_INPUT_SELECT     8'h38
`define RMS_ADR_TIMER5_INPUT_SELECT     8'h3C
`define RMS_ADR_VIRTUAL_PIN_A_SELECT    8'h40
`define RMS_ADR_VIRTUAL_PIN_B_SELECT    8'h44
`define RMS_ADR_PIN_LEVEL_LO            8'h48
`define RMS_ADR_PIN_LEVEL_HI            8'h4C
`define RMS_ADR_ROUTED_LEVEL            8'h50

// ----------------------------------------------------------------------
// register indices inside the selector array
// ----------------------------------------------------------------------
`define RMS_IDX_UART3     5'd0
`define RMS_IDX_UART4     5'd1
`define RMS_IDX_SER_IN1   5'd2
`define RMS_IDX_SER_IN2   5'd3
`define RMS_IDX_FAULT     5'd4
`define RMS_IDX_NOTIFY_A  5'd5
`define RMS_IDX_NOTIFY_B  5'd6
`define RMS_IDX_EXT_EXTERNAL_INTERRUPT_1  5'd7
`define RMS_IDX_CARRIER   5'd8
`define RMS_IDX_CAPT5     5'd9
`define RMS_IDX_CAPT7     5'd10
`define RMS_IDX_CAPT8_9   5'd11
`define RMS_IDX_TIMER0    5'd12
`define RMS_IDX_TIMER1    5'd13
`define RMS_IDX_TIMER3    5'd14
`define RMS_IDX_TIMER5    5'd15
`define RMS_IDX_VPIN_A    5'd16
`define RMS_IDX_VPIN_B    5'd17
`define RMS_REG_COUNT     18

// ----------------------------------------------------------------------
// fields, groups, encodings, reset
// ----------------------------------------------------------------------
`define RMS_NIB_HI        1'b1
`define RMS_NIB_LO        1'b0
`define RMS_GRP_4N        1'b0
`define RMS_GRP_4N1       1'b1
`define RMS_SEL_WIDTH     4
`define RMS_SEL_LAST_PIN  4'hB
`define RMS_SEL_GROUND    4'hF
`define RMS_SEL_RESET     8'hFF
`define RMS_PIN_COUNT     46
`define RMS_OUT_COUNT     29

`endif

// file: src/rms_pin_select.v
`timescale 1ns/1ps
`default_nettype none
`include "rms_defines.vh"

module rms_pin_select #(
  parameter GROUP = 0,
  parameter PINS  = `RMS_PIN_COUNT
) (
  input  wire [`RMS_SEL_WIDTH-1:0] i_select,
  input  wire [PINS-1:0]           i_pins,
  output reg                       o_level
);

  // ----------------------------------------------------------------------
  // pin index is select*4 plus the group offset
  // ----------------------------------------------------------------------
  wire [5:0] pin_idx;

  assign pin_idx = {i_select, 1'b0, GROUP[0]};

  always @* begin
    // 12..14 reach no pin and 15 is ground: both read low
    if (i_select <= `RMS_SEL_LAST_PIN) begin
      o_level = i_pins[pin_idx];
    end else begin
      o_level = 1'b0;
    end
  end

endmodule // rms_pin_select

`default_nettype wire

// file: src/rms_input_selector.v
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rms_defines.vh"

// Behaviour
// - each input steered by one nibble field
// - group 4n inputs use fixed field positions
// - group 4n+1 inputs use fixed field positions
// - 4n values 0-11 pick pins 0..44
// - 4n+1 values 0-11 pick pins 1..45
// - 4n+1 values 12-14 none, 15 ground
module rms_input_selector #(
  parameter PINS = `RMS_PIN_COUNT
) (
  input  wire        i_clock,
  input  wire        i_rst,
  // wishbone classic slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output wire [31:0] o_wb_dat,
  output wire        o_wb_ack,
  // remappable pins
  input  wire [PINS-1:0] i_remappable_pin,
  // group 4n peripheral inputs
  output wire        o_serial_data_in_1,
  output wire        o_fault_input_0,
  output wire        o_change_notify_0,
  output wire        o_change_notify_4,
  output wire        o_carrier_in_1,
  output wire        o_timer0_clock_in,
  output wire        o_timer5_gate_in,
  output wire        o_uart3_receive_in,
  output wire        o_uart4_receive_in,
  output wire        o_capture5_in,
  output wire        o_capture8_in,
  output wire        o_virtual_pin_0,
  output wire        o_virtual_pin_4,
  // group 4n+1 peripheral inputs
  output wire        o_serial_data_in_2,
  output wire        o_external_interrupt_1,
  output wire        o_change_notify_1,
  output wire        o_change_notify_5,
  output wire        o_carrier_in_2,
  output wire        o_timer1_clock_in,
  output wire        o_timer1_gate_in,
  output wire        o_timer3_clock_in,
  output wire        o_timer3_gate_in,
  output wire        o_timer5_clock_in,
  output wire        o_uart3_transmit_in,
  output wire        o_uart4_transmit_in,
  output wire        o_capture7_in,
  output wire        o_capture9_in,
  output wire        o_virtual_pin_1,
  output wire        o_virtual_pin_5
);

  // ----------------------------------------------------------------------
  // routing table: {group, nibble, register index} per output
  // ----------------------------------------------------------------------
  function [6:0] map_entry;
    input integer k;
    begin
      case (k)
        0:  map_entry = {`RMS_GRP_4N,  `RMS_NIB_HI, `RMS_IDX_SER_IN1};
        1:  map_entry = {`RMS_GRP_4N,  `RMS_NIB_LO, `RMS_IDX_FAULT};
        2:  map_entry = {`RMS_GRP_4N,  `RMS_NIB_LO, `RMS_IDX_NOTIFY_A};
        3:  map_entry = {`RMS_GRP_4N,  `RMS_NIB_LO, `RMS_IDX_NOTIFY_B};
        4:  map_entry = {`RMS_GRP_4N,  `RMS_NIB_LO, `RMS_IDX_CARRIER};
        5:  map_entry = {`RMS_GRP_4N,  `RMS_NIB_HI, `RMS_IDX_TIMER0};
        6:  map_entry = {`RMS_GRP_4N,  `RMS_NIB_LO, `RMS_IDX_TIMER5};
        7:  map_entry = {`RMS_GRP_4N,  `RMS_NIB_LO, `RMS_IDX_UART3};
        8:  map_entry = {`RMS_GRP_4N,  `RMS_NIB_LO, `RMS_IDX_UART4};
        9:  map_entry = {`RMS_GRP_4N,  `RMS_NIB_HI, `RMS_IDX_CAPT5};
        10: map_entry = {`RMS_GRP_4N,  `RMS_NIB_LO, `RMS_IDX_CAPT8_9};
        11: map_entry = {`RMS_GRP_4N,  `RMS_NIB_LO, `RMS_IDX_VPIN_A};
        12: map_entry = {`RMS_GRP_4N,  `RMS_NIB_LO, `RMS_IDX_VPIN_B};
        13: map_entry = {`RMS_GRP_4N1, `RMS_NIB_LO, `RMS_IDX_SER_IN2};
        14: map_entry = {`RMS_GRP_4N1, `RMS_NIB_LO, `RMS_IDX_EXT_EXTERNAL_INTERRUPT_1};
        15: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_NOTIFY_A};
        16: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_NOTIFY_B};
        17: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_CARRIER};
        18: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_TIMER1};
        19: map_entry = {`RMS_GRP_4N1, `RMS_NIB_LO, `RMS_IDX_TIMER1};
        20: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_TIMER3};
        21: map_entry = {`RMS_GRP_4N1, `RMS_NIB_LO, `RMS_IDX_TIMER3};
        22: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_TIMER5};
        23: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_UART3};
        24: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_UART4};
        25: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_CAPT7};
        26: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_CAPT8_9};
        27: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_VPIN_A};
        default: map_entry = {`RMS_GRP_4N1, `RMS_NIB_HI, `RMS_IDX_VPIN_B};
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // address decode: selector index, or 5'h1F when not a selector
  // ----------------------------------------------------------------------
  function [4:0] sel_index;
    input [7:0] adr;
    begin
      if (adr[7:2] < `RMS_REG_COUNT) begin
        sel_index = adr[6:2];
      end else begin
        sel_index = 5'h1F;
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg  [7:0]                sel_r [0:`RMS_REG_COUNT-1];
  reg  [PINS-1:0]           pin_meta_r;
  reg  [PINS-1:0]           pin_sync_r;
  reg  [`RMS_OUT_COUNT-1:0] periph_r;
  wire [`RMS_OUT_COUNT-1:0] periph_nxt;
  reg                       ack_r;
  wire                      ack_nxt;
  reg  [31:0]               rdat_r;
  reg  [31:0]               rdat_nxt;
  wire [4:0]                bus_idx;
  wire                      bus_req;
  wire                      wr_commit;
  integer                   i;

  assign bus_req   = i_wb_cyc & i_wb_stb;
  assign bus_idx   = sel_index(i_wb_adr);
  // ack goes high one edge after the request and drops the edge after
  assign ack_nxt   = bus_req & ~ack_r;
  // the write lands at the same edge the master sees ack
  assign wr_commit = bus_req & ack_r & i_wb_we & i_wb_sel[0];

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // pins are asynchronous; only the second stage feeds the muxes
  always @(posedge i_clock) begin
    if (i_rst) begin
      pin_meta_r <= {PINS{1'b0}};
      pin_sync_r <= {PINS{1'b0}};
    end else begin
      pin_meta_r <= i_remappable_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // per-input selector muxes
  // ----------------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < `RMS_OUT_COUNT; k = k + 1) begin : g_route
      localparam [6:0] ENTRY = map_entry(k);
      wire [`RMS_SEL_WIDTH-1:0] field;

      // upper or lower nibble of the paired register
      assign field = ENTRY[5] ? sel_r[ENTRY[4:0]][7:4] : sel_r[ENTRY[4:0]][3:0];

      rms_pin_select #(
        .GROUP (ENTRY[6]),
        .PINS  (PINS)
      ) u_sel (
        .i_select (field),
        .i_pins   (pin_sync_r),
        .o_level  (periph_nxt[k])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      periph_r <= {`RMS_OUT_COUNT{1'b0}};
    end else begin
      periph_r <= periph_nxt;
    end
  end

  assign o_serial_data_in_1     = periph_r[0];
  assign o_fault_input_0        = periph_r[1];
  assign o_change_notify_0      = periph_r[2];
  assign o_change_notify_4      = periph_r[3];
  assign o_carrier_in_1         = periph_r[4];
  assign o_timer0_clock_in      = periph_r[5];
  assign o_timer5_gate_in       = periph_r[6];
  assign o_uart3_receive_in     = periph_r[7];
  assign o_uart4_receive_in     = periph_r[8];
  assign o_capture5_in          = periph_r[9];
  assign o_capture8_in          = periph_r[10];
  assign o_virtual_pin_0        = periph_r[11];
  assign o_virtual_pin_4        = periph_r[12];
  assign o_serial_data_in_2     = periph_r[13];
  assign o_external_interrupt_1 = periph_r[14];
  assign o_change_notify_1      = periph_r[15];
  assign o_change_notify_5      = periph_r[16];
  assign o_carrier_in_2         = periph_r[17];
  assign o_timer1_clock_in      = periph_r[18];
  assign o_timer1_gate_in       = periph_r[19];
  assign o_timer3_clock_in      = periph_r[20];
  assign o_timer3_gate_in       = periph_r[21];
  assign o_timer5_clock_in      = periph_r[22];
  assign o_uart3_transmit_in    = periph_r[23];
  assign o_uart4_transmit_in    = periph_r[24];
  assign o_capture7_in          = periph_r[25];
  assign o_capture9_in          = periph_r[26];
  assign o_virtual_pin_1        = periph_r[27];
  assign o_virtual_pin_5        = periph_r[28];

  // ----------------------------------------------------------------------
  // selector registers
  // ----------------------------------------------------------------------
  // reset to ground so no peripheral sees a pin before software routes it
  always @(posedge i_clock) begin
    if (i_rst) begin
      for (i = 0; i < `RMS_REG_COUNT; i = i + 1) begin
        sel_r[i] <= `RMS_SEL_RESET;
      end
    end else if (wr_commit && (bus_idx != 5'h1F)) begin
      sel_r[bus_idx] <= i_wb_dat[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always @* begin
    rdat_nxt = 32'h0000_0000;
    if (bus_idx != 5'h1F) begin
      rdat_nxt = {24'h00_0000, sel_r[bus_idx]};
    end else if (i_wb_adr[7:2] == `RMS_ADR_PIN_LEVEL_LO >> 2) begin
      rdat_nxt = pin_sync_r[31:0];
    end else if (i_wb_adr[7:2] == `RMS_ADR_PIN_LEVEL_HI >> 2) begin
      rdat_nxt = {{(64-PINS){1'b0}}, pin_sync_r[PINS-1:32]};
    end else if (i_wb_adr[7:2] == `RMS_ADR_ROUTED_LEVEL >> 2) begin
      rdat_nxt = {{(32-`RMS_OUT_COUNT){1'b0}}, periph_r};
    end else begin
      // unmapped: acknowledged, reads zero, writes dropped
      rdat_nxt = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= ack_nxt;
      rdat_r <= ack_nxt ? rdat_nxt : 32'h0000_0000;
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;

endmodule // rms_input_selector

`default_nettype wire

// file: tb/rms_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module rms_pin_model #(
  parameter PINS = 46
) (
  input  wire logic            i_clock,
  input  wire logic [5:0]      i_pick,
  input  wire logic            i_invert,
  output var  logic [PINS-1:0] o_pins
);
  // pads settle after the edge; a pick past the last pin leaves all pins at the base level
  initial o_pins = '0;
  always @(posedge i_clock) begin
    o_pins <= {PINS{i_invert}} ^ (PINS'(1) << i_pick);
  end
endmodule // rms_pin_model
`default_nettype wire

// file: tb/rms_input_selector_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "rms_defines.vh"
module rms_input_selector_chk #(
  parameter PINS = 46
) (
  input wire logic            i_clock,
  input wire logic            i_rst,
  input wire logic            i_wb_cyc,
  input wire logic            i_wb_stb,
  input wire logic            i_wb_we,
  input wire logic [7:0]      i_wb_adr,
  input wire logic [3:0]      i_wb_sel,
  input wire logic [31:0]     i_wb_dat,
  input wire logic [31:0]     o_wb_dat,
  input wire logic            o_wb_ack,
  input wire logic [PINS-1:0] i_remappable_pin,
  input wire logic            o_serial_data_in_1,
  input wire logic            o_fault_input_0,
  input wire logic            o_timer1_clock_in,
  input wire logic            o_timer1_gate_in
);
  // ------------------------------------------------------------
  // shadow selectors and a settle counter
  // ------------------------------------------------------------
  logic [7:0]      ser1_r;
  logic [7:0]      flt_r;
  logic [7:0]      tm1_r;
  logic [PINS-1:0] pin_q_r;
  logic [2:0]      quiet_r;
  logic            wr;
  logic            calm;
  assign wr   = i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0] & o_wb_ack;
  // routes are only judged once pins and selectors sat still past the sync delay
  // a pin that moved at this edge is not yet seen by the outputs, so it blocks the judgement
  assign calm = quiet_r[2] && (i_remappable_pin == pin_q_r);
  always @(posedge i_clock) begin
    pin_q_r <= i_remappable_pin;
    if (i_rst) begin
      ser1_r  <= 8'hFF;
      flt_r   <= 8'hFF;
      tm1_r   <= 8'hFF;
      quiet_r <= 3'h0;
    end else begin
      if (wr && i_wb_adr[7:2] == 6'h02) ser1_r <= i_wb_dat[7:0];
      if (wr && i_wb_adr[7:2] == 6'h04) flt_r <= i_wb_dat[7:0];
      if (wr && i_wb_adr[7:2] == 6'h0D) tm1_r <= i_wb_dat[7:0];
      if (wr || i_remappable_pin != pin_q_r) quiet_r <= 3'h0;
      else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
    end
  end
  function automatic logic m4(input logic [3:0] v, input logic [PINS-1:0] p);
    m4 = (v <= 4'hB) ? p[{v, 2'b00}] : 1'b0;
  endfunction
  function automatic logic m41(input logic [3:0] v, input logic [PINS-1:0] p);
    m41 = (v <= 4'hB) ? p[{v, 2'b01}] : 1'b0;
  endfunction
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  property p_ack_once;
    s_req |=> s_pulse;
  endproperty
  property p_readback;
    o_wb_ack && !i_wb_we && i_wb_adr == `RMS_ADR_SERIAL_IN1_INPUT_SELECT
      |-> o_wb_dat == {24'h0, ser1_r};
  endproperty
  property p_even_field;
    calm |-> o_serial_data_in_1 == m4(ser1_r[7:4], i_remappable_pin)
          && o_fault_input_0 == m4(flt_r[3:0], i_remappable_pin);
  endproperty
  property p_odd_field;
    calm |-> o_timer1_clock_in == m41(tm1_r[7:4], i_remappable_pin)
          && o_timer1_gate_in == m41(tm1_r[3:0], i_remappable_pin);
  endproperty
  property p_even_low;
    calm && ser1_r[7:4] <= 4'h7 |-> o_serial_data_in_1 == i_remappable_pin[{ser1_r[7:4], 2'b00}];
  endproperty
  property p_odd_pins;
    calm && tm1_r[7:4] <= 4'hB |-> o_timer1_clock_in == i_remappable_pin[{tm1_r[7:4], 2'b01}];
  endproperty
  property p_odd_none;
    calm && tm1_r[3:0] >= 4'hC |-> !o_timer1_gate_in;
  endproperty
  property p_even_high;
    calm && flt_r[3:0] >= 4'h8 |-> o_fault_input_0 == m4(flt_r[3:0], i_remappable_pin);
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
  a_readback: assert property (p_readback) else $error("selector readback differs");
  a_even_field: assert property (p_even_field) else $error("even route wrong");
  a_odd_field: assert property (p_odd_field) else $error("odd route wrong");
  a_even_low: assert property (p_even_low) else $error("even low pin wrong");
  a_odd_pins: assert property (p_odd_pins) else $error("odd pin wrong");
  a_odd_none: assert property (p_odd_none) else $error("odd unconnected not low");
  a_even_high: assert property (p_even_high) else $error("even upper value wrong");
endmodule // rms_input_selector_chk
bind rms_input_selector rms_input_selector_chk #(.PINS(PINS)) u_chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_remappable_pin(i_remappable_pin),
  .o_serial_data_in_1(o_serial_data_in_1), .o_fault_input_0(o_fault_input_0),
  .o_timer1_clock_in(o_timer1_clock_in), .o_timer1_gate_in(o_timer1_gate_in));
`default_nettype wire

// file: tb/tb_rms_input_selector.sv
`timescale 1ns/1ps
`default_nettype none
`include "rms_defines.vh"
module tb_rms_input_selector;
  logic        clock = 1'b0;
  logic        rst   = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [5:0]  pick  = 6'h3F;
  logic        inv   = 1'b0;
  wire  [31:0] rdat;
  wire         ack;
  wire  [45:0] pins;
  wire  [28:0] routed;
  wire         ser1, flt, tclk, tgate;
  assign ser1  = routed[0];
  assign flt   = routed[1];
  assign tclk  = routed[18];
  assign tgate = routed[19];
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #12.5 clock = ~clock;
  rms_pin_model #(.PINS(46)) u_pins (.i_clock(clock), .i_pick(pick), .i_invert(inv), .o_pins(pins));
  rms_input_selector #(.PINS(46)) uut (
    .i_clock(clock), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_remappable_pin(pins),
    .o_serial_data_in_1(routed[0]), .o_fault_input_0(routed[1]),
    .o_change_notify_0(routed[2]), .o_change_notify_4(routed[3]),
    .o_carrier_in_1(routed[4]), .o_timer0_clock_in(routed[5]),
    .o_timer5_gate_in(routed[6]), .o_uart3_receive_in(routed[7]),
    .o_uart4_receive_in(routed[8]), .o_capture5_in(routed[9]),
    .o_capture8_in(routed[10]), .o_virtual_pin_0(routed[11]),
    .o_virtual_pin_4(routed[12]), .o_serial_data_in_2(routed[13]),
    .o_external_interrupt_1(routed[14]), .o_change_notify_1(routed[15]),
    .o_change_notify_5(routed[16]), .o_carrier_in_2(routed[17]),
    .o_timer1_clock_in(routed[18]), .o_timer1_gate_in(routed[19]),
    .o_timer3_clock_in(routed[20]), .o_timer3_gate_in(routed[21]),
    .o_timer5_clock_in(routed[22]), .o_uart3_transmit_in(routed[23]),
    .o_uart4_transmit_in(routed[24]), .o_capture7_in(routed[25]),
    .o_capture9_in(routed[26]), .o_virtual_pin_1(routed[27]),
    .o_virtual_pin_5(routed[28]));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] rd);
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    // ends on ack; without ack only the bench timeout ends this wait
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] rd;
    for (int i = 0; i < 18; i++) begin
      wb(1'b0, 8'(i * 4), 4'hF, 32'h0, rd);
      chk(rd, 32'h0000_00FF);
    end
    wb(1'b0, 8'h60, 4'hF, 32'h0, rd);
    chk(rd, 32'h0);
    chk({ser1, flt, tclk, tgate}, 4'h0);
  endtask
  task automatic t_fields;
    logic [31:0] rd;
    wb(1'b1, `RMS_ADR_TIMER1_INPUT_SELECT, 4'hF, 32'hFFFF_FFF0, rd);
    wb(1'b0, `RMS_ADR_TIMER1_INPUT_SELECT, 4'hF, 32'h0, rd);
    chk(rd, 32'h0000_00F0);
    pick <= 6'd1;
    inv  <= 1'b0;
    repeat (6) @(posedge clock);
    chk({tclk, tgate}, 2'b01);
    // a write with lane 0 off must leave the selector alone
    wb(1'b1, `RMS_ADR_TIMER1_INPUT_SELECT, 4'hE, 32'h0, rd);
    wb(1'b0, `RMS_ADR_TIMER1_INPUT_SELECT, 4'hF, 32'h0, rd);
    chk(rd, 32'h0000_00F0);
  endtask
  task automatic t_scan;
    logic [31:0] rd;
    logic [3:0]  v;
    logic        e;
    for (int k = 0; k < 32; k++) begin
      v = 4'(k >> 1);
      inv <= k[0];
      e = (v <= 4'hB) ? ~k[0] : 1'b0;
      wb(1'b1, `RMS_ADR_SERIAL_IN1_INPUT_SELECT, 4'h1, {24'h0, v, v}, rd);
      wb(1'b1, `RMS_ADR_FAULT_INPUT_SELECT, 4'h1, {24'h0, v, v}, rd);
      wb(1'b1, `RMS_ADR_TIMER1_INPUT_SELECT, 4'h1, {24'h0, v, v}, rd);
      pick <= {v, 2'b00};
      repeat (6) @(posedge clock);
      chk(ser1, e);
      chk(flt, e);
      pick <= {v, 2'b01};
      repeat (6) @(posedge clock);
      chk(tclk, e);
      chk(tgate, e);
    end
  endtask
  // every selector 8'h10: hi nibble reaches pin 4 or 5, lo nibble pin 0 or 1
  task automatic t_routes;
    logic [31:0] rd;
    logic [5:0]  p;
    logic [28:0] m;
    inv <= 1'b0;
    for (int i = 0; i < 18; i++) begin
      wb(1'b1, 8'(i * 4), 4'h1, 32'h0000_0010, rd);
    end
    for (int j = 0; j < 4; j++) begin
      p = {3'h0, j[1], 1'b0, j[0]};
      m = (j == 0) ? 29'h0000_1DDE : (j == 1) ? 29'h0028_6000 :
          (j == 2) ? 29'h0000_0221 : 29'h1FD7_8000;
      pick <= p;
      repeat (6) @(posedge clock);
      chk(routed, m);
      chk(routed, m);
      wb(1'b0, `RMS_ADR_ROUTED_LEVEL, 4'hF, 32'h0, rd);
      chk(rd, m);
      wb(1'b0, `RMS_ADR_PIN_LEVEL_LO, 4'hF, 32'h0, rd);
      chk(rd, 32'h1 << p);
    end
    pick <= 6'h2D;
    repeat (6) @(posedge clock);
    wb(1'b0, `RMS_ADR_PIN_LEVEL_HI, 4'hF, 32'h0, rd);
    chk(rd, 32'h0000_2000);
    // a reset in mid-run must put every selector back to ground
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    wb(1'b0, `RMS_ADR_TIMER1_INPUT_SELECT, 4'hF, 32'h0, rd);
    chk(rd, 32'h0000_00FF);
    repeat (4) @(posedge clock);
    chk(routed, 29'h0000_0000);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_scan();
    t_routes();
    conclude();
  end
endmodule // tb_rms_input_selector
`default_nettype wire
